// *** hw/dimm_ctl_pkg.sv ***
// Constants and carrier types for the two-slot DIMM DRAM controller.
// Assumes one 125 MHz system clock; DRAM timing is counted in its cycles.
package dimm_ctl_pkg;
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned CLK_PERIOD_PS  = 8000;
  // Refresh interval, in nanoseconds times ten (15.6 us)
  localparam int unsigned REFRESH_NS_X10 = 156000;
  localparam int unsigned REFRESH_CYC    = (REFRESH_NS_X10 * 100) / CLK_PERIOD_PS; // Longest: round down
  // Row access time in ns, counted as a least time
  localparam int unsigned RAS_ACCESS_NS  = 70;
  localparam int unsigned RAS_CYC        = (RAS_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ROW_HOLD_NS    = 16;
  localparam int unsigned ROW_HOLD_CYC   = (ROW_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CAS_NS         = 24;
  localparam int unsigned CAS_CYC        = (CAS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PRECHARGE_NS   = 56;
  localparam int unsigned PRE_CYC        = (PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ADDR_W         = 12;
  localparam int unsigned DATA_W         = 64;
  localparam int unsigned LANES          = 8;
  localparam int unsigned BANKS          = 4;
  localparam int unsigned CPU_ADDR_W     = 32;
  // Bank size codes, MB per bank: 0 means empty
  localparam logic [5:0]  BANK_MIN_MB    = 6'h04;
  localparam logic [5:0]  BANK_MAX_MB    = 6'h20;
  localparam logic [6:0]  MB_SHIFT       = 7'h14;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  cas_n;
    logic [BANKS-1:0]  ras_n;
    logic [1:0]        we_n;
    logic [1:0]        oe_n;
  } dram_ctl_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [CPU_ADDR_W-1:0] addr;
    logic [LANES-1:0]  lanes;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;
endpackage

// *** hw/dimm_dram_controller.sv ***
// Two-slot, four-bank asynchronous DRAM controller on the system clock.
// Assumes bank sizes come from board straps (MB per bank, 0 = empty)
// and the requester holds a request until o_req_ready pulses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 64-bit shared data path, three-signal pins
// - One 12-bit multiplexed address bus
// - Row phase maps address bits 22,23,21..12
// - Column phase maps 24,22,11..3
// - Mapping covers all listed device geometries
// - Column-before-row refresh every 15.6 us
// - Linear banks, no interleave
// - Any size any slot, contiguous map
// - Eight active-low column strobes per lane
// - Four active-low row strobes per bank
// - Presence and identity lines left unused
// - Banks 4 to 32 MB, 64 MB modules
module dimm_dram_controller #(
  parameter int unsigned REFRESH_CYCLES = dimm_ctl_pkg::REFRESH_CYC
) (
  input  wire logic                             i_clk,
  input  wire logic                             i_rst_n,
  input  wire dimm_ctl_pkg::mem_req_t           i_req,
  input  wire logic [dimm_ctl_pkg::BANKS*6-1:0] i_bank_mb,
  input  wire logic [dimm_ctl_pkg::DATA_W-1:0]  i_dq,
  input  wire logic [15:0]                      i_presence_bits,
  input  wire logic [3:0]                       i_module_identity_bits,
  output logic                                  o_req_ready,
  output logic [dimm_ctl_pkg::DATA_W-1:0]       o_rdata,
  output logic                                  o_rdata_valid,
  output logic                                  o_miss,
  output dimm_ctl_pkg::dram_ctl_t               o_dram,
  output logic [dimm_ctl_pkg::DATA_W-1:0]       o_dq,
  output logic                                  o_dq_oe,
  output logic [1:0]                            o_presence_read_enable_n
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ROW  = 3'b001,
    ST_COL  = 3'b010,
    ST_PRE  = 3'b011,
    ST_RCAS = 3'b100,
    ST_RRAS = 3'b101
  } state_t;

  state_t                                   state_r;
  logic [7:0]                               cnt_r;
  logic [15:0]                              ref_cnt_r;
  logic                                     ref_due_r;
  logic [dimm_ctl_pkg::BANKS-1:0]           bank_r;
  logic [dimm_ctl_pkg::CPU_ADDR_W-1:0]      local_r;
  logic                                     hit;
  logic [dimm_ctl_pkg::BANKS-1:0]           bank_sel;
  logic [dimm_ctl_pkg::CPU_ADDR_W-1:0]      local_addr;
  logic [dimm_ctl_pkg::DATA_W-1:0]          dq_s1_r;
  logic [dimm_ctl_pkg::DATA_W-1:0]          dq_s2_r;
  logic [dimm_ctl_pkg::BANKS*6-1:0]         mb_s1_r;
  logic [dimm_ctl_pkg::BANKS*6-1:0]         mb_s2_r;

  // lines unused: presence enable held inactive, identity ignored
  assign o_presence_read_enable_n = 2'h3;

  function automatic logic [11:0] row_of(input logic [31:0] a);
    row_of = {a[22], a[23], a[21:12]};
  endfunction

  // column mapping, line 11 idle low
  function automatic logic [11:0] col_of(input logic [31:0] a);
    col_of = {1'b0, a[24], a[22], a[11:3]};
  endfunction

  // contiguous decode: banks stacked in order, empty banks skipped
  // no interleave, each bank one linear span
  always_comb begin
    logic [31:0] base;
    logic [31:0] size;
    base       = 32'h0000_0000;
    size       = 32'h0000_0000;
    hit        = 1'b0;
    bank_sel   = '0;
    local_addr = '0;
    for (int b = 0; b < dimm_ctl_pkg::BANKS; b++) begin
      // banks outside 4..32 MB treated as empty
      if (mb_s2_r[b*6 +: 6] >= dimm_ctl_pkg::BANK_MIN_MB && mb_s2_r[b*6 +: 6] <= dimm_ctl_pkg::BANK_MAX_MB) begin
        size = {26'h0, mb_s2_r[b*6 +: 6]} << dimm_ctl_pkg::MB_SHIFT;
      end else begin
        size = 32'h0000_0000;
      end
      if (!hit && size != 32'h0 && i_req.addr >= base && i_req.addr < base + size) begin
        hit        = 1'b1;
        bank_sel   = dimm_ctl_pkg::BANKS'(1 << b);
        local_addr = i_req.addr - base;
      end
      base = base + size;
    end
  end

  // refresh interval timer; due flag set wins over consumption
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_cnt_r <= 16'h0000;
      ref_due_r <= 1'b0;
    end else begin
      if (ref_cnt_r == 16'(REFRESH_CYCLES - 1)) begin
        ref_cnt_r <= 16'h0000;
        ref_due_r <= 1'b1;
      end else begin
        ref_cnt_r <= ref_cnt_r + 16'h0001;
        if (state_r == ST_RCAS && cnt_r == 8'h00) begin
          ref_due_r <= 1'b0;
        end
      end
    end
  end

  // read data passes two flops from the pins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= i_dq;
      dq_s2_r <= dq_s1_r;
    end
  end

  // Bank size straps are board pins: two flops; decode sees empty banks just after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mb_s1_r <= '0;
      mb_s2_r <= '0;
    end else begin
      mb_s1_r <= i_bank_mb;
      mb_s2_r <= mb_s1_r;
    end
  end

  // Access sequencer; phase lengths sized for 70 ns parts
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r       <= ST_IDLE;
      cnt_r         <= 8'h00;
      bank_r        <= '0;
      local_r       <= '0;
      o_dram        <= '{addr: 12'h000, cas_n: 8'hFF, ras_n: 4'hF, we_n: 2'h3, oe_n: 2'h3};
      o_dq          <= '0;
      o_dq_oe       <= 1'b0;
      o_rdata       <= '0;
      o_rdata_valid <= 1'b0;
      o_miss        <= 1'b0;
      o_req_ready   <= 1'b0;
    end else begin
      o_rdata_valid <= 1'b0;
      o_miss        <= 1'b0;
      o_req_ready   <= 1'b0;
      if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
      case (state_r)
        ST_IDLE: begin
          // pending refresh runs before any new access
          if (ref_due_r) begin
            o_dram.cas_n <= 8'h00;
            cnt_r        <= 8'(dimm_ctl_pkg::CAS_CYC - 1);
            state_r      <= ST_RCAS;
          end else if (i_req.valid && !o_req_ready) begin
            if (!hit) begin
              o_miss      <= 1'b1;
              o_req_ready <= 1'b1;
            end else begin
              bank_r  <= bank_sel;
              local_r <= local_addr;
              // row phase on shared address bus
              o_dram.addr  <= row_of(local_addr);
              // one row strobe per accessed bank
              o_dram.ras_n <= ~bank_sel;
              cnt_r        <= 8'(dimm_ctl_pkg::ROW_HOLD_CYC - 1);
              state_r      <= ST_ROW;
            end
          end
        end
        ST_ROW: begin
          if (cnt_r == 8'h00) begin
            o_dram.addr <= col_of(local_r);
            o_dram.cas_n <= ~i_req.lanes;
            // exactly one of write or output enable
            if (i_req.write) begin
              o_dram.we_n <= 2'h0;
              o_dq        <= i_req.wdata;
              o_dq_oe     <= 1'b1;
            end else begin
              o_dram.oe_n <= 2'h0;
            end
            cnt_r   <= 8'(dimm_ctl_pkg::RAS_CYC - dimm_ctl_pkg::ROW_HOLD_CYC);
            state_r <= ST_COL;
          end
        end
        ST_COL: begin
          if (cnt_r == 8'h00) begin
            if (!i_req.write) begin
              o_rdata       <= dq_s2_r;
              o_rdata_valid <= 1'b1;
            end
            o_req_ready  <= 1'b1;
            o_dram       <= '{addr: o_dram.addr, cas_n: 8'hFF, ras_n: 4'hF, we_n: 2'h3, oe_n: 2'h3};
            o_dq_oe      <= 1'b0;
            cnt_r        <= 8'(dimm_ctl_pkg::PRE_CYC - 1);
            state_r      <= ST_PRE;
          end
        end
        ST_RCAS: begin
          if (cnt_r == 8'h00) begin
            o_dram.ras_n <= 4'h0;
            cnt_r        <= 8'(dimm_ctl_pkg::RAS_CYC - 1);
            state_r      <= ST_RRAS;
          end
        end
        ST_RRAS: begin
          if (cnt_r == 8'h00) begin
            o_dram.ras_n <= 4'hF;
            o_dram.cas_n <= 8'hFF;
            cnt_r        <= 8'(dimm_ctl_pkg::PRE_CYC - 1);
            state_r      <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (cnt_r == 8'h00) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verif/dimm_ctl_properties.sv ***
// Port checker for the DIMM DRAM controller.
// Assumes the bind below hands on the refresh count.
`timescale 1ns/1ps
`default_nettype none
module dimm_ctl_checker #(
  parameter int unsigned REFRESH_CYCLES = dimm_ctl_pkg::REFRESH_CYC
) (
  input wire logic                    i_clk,
  input wire logic                    i_rst_n,
  input wire dimm_ctl_pkg::mem_req_t  i_req,
  input wire logic                    o_req_ready,
  input wire logic                    o_miss,
  input wire dimm_ctl_pkg::dram_ctl_t o_dram,
  input wire logic [1:0]              o_presence_read_enable_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [31:0] a;
  logic [31:0] gap_r;
  assign a = i_req.addr;
  sequence s_cbr; $fell(&o_dram.cas_n) && &o_dram.ras_n; endsequence
  sequence s_col0; $fell(&o_dram.cas_n) && !o_dram.ras_n[0]; endsequence
  // Cycles since a refresh began; bounds a late refresh
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) gap_r <= '0;
    else if (&o_dram.ras_n && $fell(&o_dram.cas_n)) gap_r <= '0;
    else gap_r <= gap_r + 32'h1;
  end
  property p_we_oe; !(o_dram.we_n != 2'h3 && o_dram.oe_n != 2'h3); endproperty
  a_we_oe: assert property (p_we_oe) else $error("write and read enable together");
  property p_row; $fell(o_dram.ras_n[0]) && &o_dram.cas_n |-> o_dram.addr == {a[22], a[23], a[21:12]}; endproperty
  a_row: assert property (p_row) else $error("row address wrong");
  property p_col; s_col0 |-> o_dram.addr == {1'b0, a[24], a[22], a[11:3]}; endproperty
  a_col: assert property (p_col) else $error("column address wrong");
  property p_lane; s_col0 |-> o_dram.cas_n == ~i_req.lanes; endproperty
  a_lane: assert property (p_lane) else $error("lane strobes wrong");
  property p_cbr; s_cbr |-> ##[2:4] o_dram.ras_n == 4'h0 ##[8:10] &o_dram.ras_n; endproperty
  a_cbr: assert property (p_cbr) else $error("refresh order wrong");
  // A refresh only starts once row strobes have rested, never inside an access
  property p_order; s_cbr |-> $past(&o_dram.ras_n, 7); endproperty
  a_order: assert property (p_order) else $error("refresh cut into access");
  property p_gap; gap_r <= REFRESH_CYCLES + 40; endproperty
  a_gap: assert property (p_gap) else $error("refresh late");
  property p_bank; !(&o_dram.we_n && &o_dram.oe_n) |-> $onehot(~o_dram.ras_n); endproperty
  a_bank: assert property (p_bank) else $error("not one bank");
  property p_unused; o_presence_read_enable_n == 2'h3; endproperty
  a_unused: assert property (p_unused) else $error("presence enable driven");
  property p_miss; o_miss |-> o_req_ready; endproperty
  a_miss: assert property (p_miss) else $error("miss without ready");
endmodule
bind dimm_dram_controller dimm_ctl_checker #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req), .o_req_ready(o_req_ready), .o_miss(o_miss),
  .o_dram(o_dram), .o_presence_read_enable_n(o_presence_read_enable_n));
`default_nettype wire

// *** verif/dimm_bank_model.sv ***
// Model of the installed DIMM banks.
// Assumes strobes registered on the controller clock.
`timescale 1ns/1ps
`default_nettype none
module dimm_bank_model (
  input  wire logic                    i_clk,
  input  wire dimm_ctl_pkg::dram_ctl_t i_dram,
  input  wire logic [63:0]             i_dq,
  output logic [63:0]                  o_dq
);
  logic [63:0] mem [int];
  logic [11:0] row_r;
  logic        idle_r;
  int          key;
  assign key = int'({i_dram.ras_n, row_r, i_dram.addr});
  initial o_dq = '0;
  // Fast 12x12 array, row latched at strobe fall
  always @(posedge i_clk) begin
    idle_r <= &i_dram.ras_n;
    if (idle_r && &i_dram.cas_n && !(&i_dram.ras_n)) row_r <= i_dram.addr;
  end
  always @(posedge i_clk) begin
    if (i_dram.we_n != 2'h3 && i_dram.cas_n != 8'hFF) begin
      if (!mem.exists(key)) mem[key] = '0;
      for (int l = 0; l < 8; l++) if (!i_dram.cas_n[l]) mem[key][8*l+:8] = i_dq[8*l+:8];
    end
    o_dq <= (i_dram.oe_n != 2'h3 && i_dram.cas_n != 8'hFF && mem.exists(key)) ? mem[key] : ~o_dq;
  end
endmodule
`default_nettype wire

// *** verif/dimm_dram_controller_tb_top.sv ***
// Bench for the DIMM DRAM controller.
// Assumes the bank model answers reads; the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
`define CHK(x, y) begin n_checks++; if ((x) !== (y)) begin fail_count++; $display("ERROR %0t: %h not %h", $time, x, y); end end
module dimm_dram_controller_tb_top;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  dimm_ctl_pkg::mem_req_t req = '0;
  dimm_ctl_pkg::dram_ctl_t dram;
  logic [63:0] dq_out, dq_mod, pins, rdata;
  logic dq_oe, ready, miss, rvalid, got_valid;
  logic [15:0] pres = 16'h0;
  logic [3:0] ras_seen;
  int fail_count = 0, n_checks = 0, refreshes = 0;
  logic [31:0] seed = 32'hEBB2;
  logic [23:0] sizes = {6'h08, 6'h00, 6'h04, 6'h20};
  logic [31:0] tbl [7] = '{32'h0, 32'h01FFFFF8, 32'h02000000, 32'h02400000, 32'h02BFFFF8, 32'h02C00000, 32'hFFFFFFF8};
  always #4 i_clk = ~i_clk;
  // Controller drives the pins only while writing
  assign pins = dq_oe ? dq_out : dq_mod;
  dimm_dram_controller #(.REFRESH_CYCLES(100)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req),
    .i_bank_mb(sizes), .i_dq(pins), .i_presence_bits(pres), .i_module_identity_bits(pres[3:0]),
    .o_req_ready(ready), .o_rdata(rdata), .o_rdata_valid(rvalid), .o_miss(miss), .o_dram(dram),
    .o_dq(dq_out), .o_dq_oe(dq_oe), .o_presence_read_enable_n());
  dimm_bank_model dimms (.i_clk(i_clk), .i_dram(dram), .i_dq(pins), .o_dq(dq_mod));
  // Banks touched by accesses; refresh cycles seen
  always @(posedge i_clk) begin
    if (!(&dram.we_n && &dram.oe_n)) ras_seen |= ~dram.ras_n;
    if (&dram.ras_n && dram.cas_n == 8'h00) refreshes++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [63:0] merge(input logic [63:0] o, input logic [63:0] n, input logic [7:0] l);
    for (int i = 0; i < 8; i++) if (l[i]) o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction
  // Banks stacked in order; empty or outside 4..32 MB spans nothing
  function automatic logic [3:0] bank_of(input logic [31:0] a);
    logic [31:0] base = '0;
    logic [31:0] sz;
    for (int b = 0; b < 4; b++) begin
      sz = (sizes[6*b+:6] >= dimm_ctl_pkg::BANK_MIN_MB && sizes[6*b+:6] <= dimm_ctl_pkg::BANK_MAX_MB) ?
           (32'(sizes[6*b+:6]) << 20) : 32'h0;
      if (a >= base && a < base + sz) return 4'h1 << b;
      base += sz;
    end
    return 4'h0;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Request held until the ready pulse, bounded wait
  task automatic access(input logic wr, input logic [31:0] a, input logic [7:0] ln, input logic [63:0] wd);
    @(negedge i_clk);
    req = '{1'b1, wr, a, ln, wd};
    ras_seen = 4'h0;
    for (int i = 0; i <= 80; i++) begin
      @(posedge i_clk);
      #1;
      if (ready) begin
        got_valid = rvalid;
        break;
      end
      if (i == 80) begin
        fail_count++;
        print_verdict();
      end
    end
    @(negedge i_clk);
    req.valid = 1'b0;
  endtask
  initial begin
    logic [31:0] a;
    logic [63:0] d0, d1;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    // Bank size straps pass the two-flop synchroniser first
    repeat (2) @(posedge i_clk);
    // Full write, random-lane write, read back
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      a = {7'h0, seed[24:3], 3'h0};
      seed = lfsr(seed);
      d0 = {seed, ~seed};
      seed = lfsr(seed);
      d1 = {~seed, seed};
      pres = seed[31:16];
      access(1'b1, a, 8'hFF, d0);
      `CHK(got_valid, 1'b0)
      access(1'b1, a, seed[7:0], d1);
      access(1'b0, a, 8'hFF, 64'h0);
      `CHK(rdata, merge(d0, d1, seed[7:0]))
      `CHK(got_valid, 1'b1)
      $display("rw %0d done", k);
    end
    // Decode across an empty bank and past the top; second pass straps bank 2 below 4 MB
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        sizes[17:12] = 6'h02;
        repeat (3) @(posedge i_clk);
      end
      foreach (tbl[i]) begin
        access(1'b0, tbl[i], 8'hFF, 64'h0);
        `CHK(miss, bank_of(tbl[i]) == 4'h0)
        `CHK(ras_seen, bank_of(tbl[i]))
        `CHK(got_valid, bank_of(tbl[i]) != 4'h0)
        $display("bank %0d pass %0d done", i, p);
      end
    end
    refreshes = 0;
    repeat (130) @(posedge i_clk);
    `CHK(refreshes > 0, 1'b1)
    $display("idle done");
    print_verdict();
  end
endmodule
`default_nettype wire
